// file: hw/iwd_regs.v
/*
 * independent watchdog: ahb-lite register slave, key command decode,
 * protected divider/reload, busy flags toward the oscillator side,
 * 12-bit down-counter and reset request, sticky interrupt.
 * assumes a single ahb-lite master and a free-running oscillator pin.
 */
`timescale 1ns/1ps
`default_nettype none
`include "iwd_defines.vh"

module iwd_regs
(
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        clk_en,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    input  wire        osc_clk_pin,
    input  wire        hw_start_pin,
    output reg         wdog_reset_req,
    output reg         irq
);

    // transfer constants
    localparam [1:0] HTRANS_NONSEQ = 2'h2;
    localparam [1:0] HTRANS_SEQ    = 2'h3;
    // busy transfer length in synchronised oscillator edges; short
    // enough that a reconfigure settles within a few slow periods
    localparam [1:0] XFER_EDGES    = `IWD_XFER_EDGES;

    // counter states, one-hot
    localparam [2:0] ST_IDLE = 3'h1;
    localparam [2:0] ST_RUN  = 3'h2;
    localparam [2:0] ST_FIRE = 3'h4;

    // address phase capture
    reg        dp_wr_ff;    // data phase is a write
    reg        dp_rd_ff;    // data phase is a read
    reg [7:0]  dp_addr_ff;  // captured byte offset

    // register state
    reg        unlock_ff;                 // write access open
    reg [2:0]  div_bus_ff;                // divider, bus side
    reg [2:0]  div_osc_ff;                // divider, counter side
    reg [11:0] rel_bus_ff;                // reload, bus side
    reg [11:0] rel_osc_ff;                // reload, counter side
    reg        div_busy_ff;               // divider update busy
    reg        rel_busy_ff;               // reload update busy
    reg [1:0]  div_cnt_ff;                // edges left for divider
    reg [1:0]  rel_cnt_ff;                // edges left for reload
    reg [11:0] cnt_ff;                    // watchdog down-counter
    reg [2:0]  state_ff;                  // counter state
    reg [`IWD_IRQ_W-1:0] irq_sts_ff;     // sticky events
    reg [`IWD_IRQ_W-1:0] irq_mask_ff;    // enables
    reg        osc_d_ff;                  // previous osc level
    reg        hws_ff;                    // hardware start latched
    reg        hws_cap_ff;                // strap captured once

    wire        osc_lvl;   // synchronised oscillator
    wire        hws_lvl;   // synchronised hardware start
    wire        tick;      // divided oscillator tick
    wire        osc_edge;  // rising oscillator edge

    // nonseq or seq; idle and busy transfers do nothing
    function is_active;
        input [1:0] trans;
        begin
            is_active = (trans == HTRANS_NONSEQ)
                        || (trans == HTRANS_SEQ);
        end
    endfunction

    // word-aligned byte offset within the block
    function [7:0] word_ofs;
        input [31:0] addr;
        begin
            word_ofs = {addr[7:2], 2'b00};
        end
    endfunction

    // decoded write of the current data phase
    wire        wr_key  = dp_wr_ff && (dp_addr_ff == `IWD_OFS_KEY);
    wire        wr_div  = dp_wr_ff && (dp_addr_ff == `IWD_OFS_DIV);
    wire        wr_rel  = dp_wr_ff && (dp_addr_ff == `IWD_OFS_RELOAD);
    wire        wr_ists = dp_wr_ff && (dp_addr_ff == `IWD_OFS_IRQ_STS);
    wire        wr_imsk = dp_wr_ff && (dp_addr_ff == `IWD_OFS_IRQ_MASK);
    wire [15:0] key     = hwdata[15:0];
    wire        cmd_refresh = wr_key && (key == `IWD_KEY_REFRESH);
    wire        cmd_start   = wr_key && (key == `IWD_KEY_START);
    // accepted protected writes
    wire        div_take = wr_div && unlock_ff && !div_busy_ff;
    wire        rel_take = wr_rel && unlock_ff && !rel_busy_ff;
    // last tick at one, or at zero after a zero reload; a refresh in
    // the same cycle wins, so no false expiry event is raised
    wire        expire   = state_ff == ST_RUN && tick && !cmd_refresh
                           && (cnt_ff == 12'h001
                               || cnt_ff == `IWD_CNT_ZERO);

    assign osc_edge = osc_lvl && !osc_d_ff;

    // oscillator and strap synchronisers
    iwd_sync3 u_sync_osc
    (
        .clk   (hclk),
        .rst_n (hresetn),
        .ce    (clk_en),
        .d_in  (osc_clk_pin),
        .q_out (osc_lvl)
    );

    iwd_sync3 u_sync_hws
    (
        .clk   (hclk),
        .rst_n (hresetn),
        .ce    (clk_en),
        .d_in  (hw_start_pin),
        .q_out (hws_lvl)
    );

    // divided tick uses the counter-side divider copy
    iwd_tick u_tick
    (
        .clk     (hclk),
        .rst_n   (hresetn),
        .ce      (clk_en),
        .osc_lvl (osc_lvl),
        .div_sel (div_osc_ff),
        .restart (cmd_refresh),
        .tick    (tick)
    );

    // ahb-lite address phase capture; always zero wait, okay
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dp_wr_ff   <= 1'b0;
            dp_rd_ff   <= 1'b0;
            dp_addr_ff <= 8'h00;
            hreadyout  <= 1'b1;
            hresp      <= 1'b0;
        end
        else if (clk_en)
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (hready)
            begin
                // only nonseq or seq transfers take effect
                dp_wr_ff   <= hsel && hwrite && is_active(htrans);
                dp_rd_ff   <= hsel && !hwrite && is_active(htrans);
                dp_addr_ff <= word_ofs(haddr);
            end
            else
            begin
                dp_wr_ff <= 1'b0;
                dp_rd_ff <= 1'b0;
            end
        end
    end

    // read data, registered at the address phase so it stands in the
    // data phase; unmapped reads return zero
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata <= 32'h0000_0000;
        else if (clk_en)
        begin
            hrdata <= 32'h0000_0000;
            if (hready && hsel && !hwrite && is_active(htrans))
            begin
                case (word_ofs(haddr))
                    `IWD_OFS_DIV:
                        hrdata <= {29'h0, div_osc_ff};
                    `IWD_OFS_RELOAD:
                        hrdata <= {20'h0_0000, rel_osc_ff};
                    `IWD_OFS_STATUS:
                        hrdata <= {30'h0, rel_busy_ff, div_busy_ff};
                    `IWD_OFS_IRQ_STS:
                        hrdata <= {30'h0, irq_sts_ff};
                    `IWD_OFS_IRQ_MASK:
                        hrdata <= {30'h0, irq_mask_ff};
                    `IWD_OFS_CTRL:
                        hrdata <= {31'h0, hws_ff};
                    default:
                        hrdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // key decode, protected registers, busy transfer
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            unlock_ff   <= 1'b0;
            div_bus_ff  <= `IWD_DIV_RST;
            div_osc_ff  <= `IWD_DIV_RST;
            rel_bus_ff  <= `IWD_RELOAD_RST;
            rel_osc_ff  <= `IWD_RELOAD_RST;
            div_busy_ff <= 1'b0;
            rel_busy_ff <= 1'b0;
            div_cnt_ff  <= 2'h0;
            rel_cnt_ff  <= 2'h0;
            osc_d_ff    <= 1'b0;
        end
        else if (clk_en)
        begin
            osc_d_ff <= osc_lvl;
            if (wr_key)
                unlock_ff <= (key == `IWD_KEY_UNLOCK);
            // locked or busy writes drop with no error
            if (div_take)
            begin
                div_bus_ff  <= hwdata[2:0];
                div_busy_ff <= 1'b1;
                div_cnt_ff  <= XFER_EDGES;
            end
            else if (div_busy_ff && osc_edge)
            begin
                // copy lands on the counter side after the edges
                if (div_cnt_ff == 2'h1)
                begin
                    div_osc_ff  <= div_bus_ff;
                    div_busy_ff <= 1'b0;
                end
                div_cnt_ff <= div_cnt_ff - 2'h1;
            end
            if (rel_take)
            begin
                rel_bus_ff  <= hwdata[11:0];
                rel_busy_ff <= 1'b1;
                rel_cnt_ff  <= XFER_EDGES;
            end
            else if (rel_busy_ff && osc_edge)
            begin
                if (rel_cnt_ff == 2'h1)
                begin
                    rel_osc_ff  <= rel_bus_ff;
                    rel_busy_ff <= 1'b0;
                end
                rel_cnt_ff <= rel_cnt_ff - 2'h1;
            end
        end
    end

    // hardware-start strap caught once after reset release
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hws_ff     <= 1'b0;
            hws_cap_ff <= 1'b0;
        end
        else if (clk_en && !hws_cap_ff && osc_edge)
        begin
            hws_ff     <= hws_lvl;
            hws_cap_ff <= 1'b1;
        end
    end

    // down-counter state machine
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_ff       <= ST_IDLE;
            cnt_ff         <= `IWD_RELOAD_RST;
            wdog_reset_req <= 1'b0;
        end
        else if (clk_en)
        begin
            case (state_ff)
                ST_IDLE:
                begin
                    // start by key, or by strap; key start ignored then
                    if ((cmd_start && !hws_ff) || hws_ff)
                        state_ff <= ST_RUN;
                    if (cmd_refresh)
                        cnt_ff <= rel_osc_ff;
                end
                ST_RUN:
                begin
                    if (cmd_refresh)
                        cnt_ff <= rel_osc_ff;
                    else if (tick)
                    begin
                        cnt_ff <= cnt_ff - 12'h001;
                        if (expire)
                            state_ff <= ST_FIRE;
                    end
                end
                ST_FIRE:
                    // held until system reset
                    wdog_reset_req <= 1'b1;
                default:
                    state_ff <= ST_IDLE;
            endcase
        end
    end

    // sticky events; set beats a write-one clear
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            irq_sts_ff  <= 2'h0;
            irq_mask_ff <= 2'h0;
            irq         <= 1'b0;
        end
        else if (clk_en)
        begin
            if (wr_imsk)
                irq_mask_ff <= hwdata[1:0];
            irq_sts_ff <= (irq_sts_ff & ~(wr_ists ? hwdata[1:0] : 2'h0))
                          | {cmd_refresh, expire};
            irq <= |(irq_sts_ff & irq_mask_ff);
        end
    end

endmodule

`default_nettype wire

// file: hw/iwd_defines.vh
/*
 * constants for the watchdog register block: offsets, fields, codes
 * and resets. assumes a 32-bit ahb-lite slave at 100 mhz.
 */
`ifndef IWD_DEFINES_VH
`define IWD_DEFINES_VH

// register byte offsets
`define IWD_OFS_KEY      8'h00
`define IWD_OFS_DIV      8'h04
`define IWD_OFS_RELOAD   8'h08
`define IWD_OFS_STATUS   8'h0C
`define IWD_OFS_IRQ_STS  8'h10
`define IWD_OFS_IRQ_MASK 8'h14
`define IWD_OFS_CTRL     8'h18

// command key codes
`define IWD_KEY_UNLOCK   16'h5555
`define IWD_KEY_REFRESH  16'hAAAA
`define IWD_KEY_START    16'hCCCC

// widths and reset values
`define IWD_DIV_W        3
`define IWD_CNT_W        12
`define IWD_DIV_RST      3'h0
`define IWD_RELOAD_RST   12'hFFF
`define IWD_CNT_ZERO     12'h000

// oscillator edges that one busy transfer takes
`define IWD_XFER_EDGES   2'h2

// status bit positions
`define IWD_ST_DIV_BUSY  0
`define IWD_ST_REL_BUSY  1

// interrupt status bits
`define IWD_IRQ_EXPIRE   0
`define IWD_IRQ_REFRESH  1
`define IWD_IRQ_W        2

// control bit: hardware-started option
`define IWD_CTRL_HWSTART 0

`endif

// file: hw/iwd_sync3.v
/*
 * three-flop synchroniser with agreement check.
 * assumes d_in is asynchronous to clk.
 */
`timescale 1ns/1ps
`default_nettype none

module iwd_sync3
(
    input  wire       clk,
    input  wire       rst_n,
    input  wire       ce,
    input  wire       d_in,
    output reg        q_out
);

    reg s1_ff; // first stage, read only by s2
    reg s2_ff; // second stage
    reg s3_ff; // third stage

    // chain; output moves only when stages two and three agree
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1_ff <= 1'b0;
            s2_ff <= 1'b0;
            s3_ff <= 1'b0;
            q_out <= 1'b0;
        end
        else if (ce)
        begin
            s1_ff <= d_in;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            if (s2_ff == s3_ff)
                q_out <= s3_ff;
        end
    end

endmodule

`default_nettype wire

// file: hw/iwd_tick.v
/*
 * divided oscillator tick generator: one-cycle pulse per divided
 * oscillator period. assumes osc_lvl is already synchronised.
 */
`timescale 1ns/1ps
`default_nettype none
`include "iwd_defines.vh"

module iwd_tick
(
    input  wire       clk,
    input  wire       rst_n,
    input  wire       ce,
    input  wire       osc_lvl,
    input  wire [2:0] div_sel,
    input  wire       restart,
    output reg        tick
);

    reg       osc_d_ff;  // previous oscillator level
    reg [7:0] pre_ff;    // oscillator edge counter

    // divide code to terminal count minus one; codes above 5 give /256
    function [7:0] div_last;
        input [2:0] code;
        begin
            case (code)
                3'h0:    div_last = 8'h03;
                3'h1:    div_last = 8'h07;
                3'h2:    div_last = 8'h0F;
                3'h3:    div_last = 8'h1F;
                3'h4:    div_last = 8'h3F;
                3'h5:    div_last = 8'h7F;
                default: div_last = 8'hFF;
            endcase
        end
    endfunction

    // count rising oscillator edges, pulse at terminal count
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            osc_d_ff <= 1'b0;
            pre_ff   <= 8'h00;
            tick     <= 1'b0;
        end
        else if (ce)
        begin
            osc_d_ff <= osc_lvl;
            tick     <= 1'b0;
            if (restart)
                pre_ff <= 8'h00;
            else if (osc_lvl && !osc_d_ff)
            begin
                if (pre_ff >= div_last(div_sel))
                begin
                    pre_ff <= 8'h00;
                    tick   <= 1'b1;
                end
                else
                    pre_ff <= pre_ff + 8'h01;
            end
        end
    end

endmodule

`default_nettype wire

// file: bench/iwd_regs_sva.sv
/*
 checker for the watchdog register slave: bus answers and reset request.
 assumes binding onto iwd_regs, one clock, clk_en held high by the bench.
*/
`timescale 1ns/1ps
`default_nettype none
module iwd_regs_sva
(
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        wdog_reset_req
);
    // address phases the slave takes; clk_en ignored, tied high in bench
    wire taken_rd = hsel & hready & htrans[1] & ~hwrite;
    wire taken_wr = hsel & hready & htrans[1] & hwrite;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // read address phase at one byte address
    sequence rd_at(logic [31:0] a);
        taken_rd && haddr == a;
    endsequence
    // refresh: key write followed by its data phase
    sequence refresh_wr;
        taken_wr && haddr == 32'h0000_0000 ##1 hwdata[15:0] == 16'hAAAA;
    endsequence

    a_key_reads_zero:
        assert property (rd_at(32'h0000_0000) |=> hrdata == 32'h0000_0000)
        else $error("key register read not zero");
    a_div_upper_zero:
        assert property (rd_at(32'h0000_0004) |=> hrdata[31:3] == 29'h0)
        else $error("divider read has upper bits set");
    a_reload_upper_zero:
        assert property (rd_at(32'h0000_0008) |=> hrdata[31:12] == 20'h0)
        else $error("reload read has upper bits set");
    a_status_upper_zero:
        assert property (rd_at(32'h0000_000C) |=> hrdata[31:2] == 30'h0)
        else $error("status read has upper bits set");
    a_unmapped_zero:
        assert property (rd_at(32'h0000_001C) |=> hrdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_idle_data_zero:
        assert property (!taken_rd |=> hrdata == 32'h0000_0000)
        else $error("read data outside data phase");
    a_bus_always_okay:
        assert property (hreadyout && !hresp)
        else $error("slave stalled or answered error");
    a_reset_req_held:
        assert property ($rose(wdog_reset_req) |=> wdog_reset_req[*8])
        else $error("reset request dropped");
    a_refresh_no_expiry:
        assert property (refresh_wr ##1 !wdog_reset_req |=>
                         !wdog_reset_req[*8])
        else $error("reset request right after refresh");
endmodule

bind iwd_regs iwd_regs_sva u_sva
(
    .hclk           (hclk),
    .hresetn        (hresetn),
    .hsel           (hsel),
    .haddr          (haddr),
    .htrans         (htrans),
    .hwrite         (hwrite),
    .hwdata         (hwdata),
    .hready         (hready),
    .hrdata         (hrdata),
    .hreadyout      (hreadyout),
    .hresp          (hresp),
    .wdog_reset_req (wdog_reset_req)
);
`default_nettype wire

// file: bench/test_independent_watchdog_regs.sv
/*
 testbench for the watchdog register slave: ahb-lite tasks and sequences.
 assumes iwd_regs and iwd_defines.vh on the include path.
*/
`timescale 1ns/1ps
`default_nettype none
`include "iwd_defines.vh"
module test_independent_watchdog_regs;
    logic        hclk;      // bus clock, 100 mhz
    logic        hresetn;   // async reset, active low
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;     // tied: whole words only
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        osc_clk_pin; // slow oscillator, 8 bus cycles a period
    logic [2:0]  osc_div;
    logic        hw_start_pin; // hardware-start strap
    logic        wdog_reset_req;
    logic        irq;
    logic [31:0] rdata_smp; // hrdata as it stood before each edge
    logic [31:0] st;
    int          n_mismatch;
    int          cmp_count;
    int          cyc;
    int          n;

    // hready is fed back from the only slave
    iwd_regs dut
    (
        .hclk(hclk), .hresetn(hresetn), .clk_en(1'b1), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .osc_clk_pin(osc_clk_pin),
        .hw_start_pin(hw_start_pin), .wdog_reset_req(wdog_reset_req),
        .irq(irq)
    );

    initial
    begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    // data sampler, oscillator and cycle count share the bus edge
    always @(posedge hclk)
    begin
        rdata_smp <= hrdata;
        osc_div <= osc_div + 3'h1;
        osc_clk_pin <= osc_div[2];
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            n_mismatch = n_mismatch + 1;
            tally_and_finish;
        end
    end

    task tally_and_finish;
        $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // one single transfer; read data taken at the data phase's edge
    task automatic xfer(input logic wr, input logic [7:0] a,
                        input logic [31:0] wd, output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h00_0000, a};
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        #1 rd = rdata_smp;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] unused;
        xfer(1'b1, a, d, unused);
    endtask

    task automatic key(input logic [15:0] k);
        wr(`IWD_OFS_KEY, {16'h0000, k});
    endtask

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            $display("[ERR] %s expected %h seen %h", what, exp, got);
            n_mismatch++;
        end
    endtask

    task automatic rd_chk(input string what, input logic [7:0] a,
                          input logic [31:0] exp);
        logic [31:0] d;
        xfer(1'b0, a, 32'h0000_0000, d);
        chk(what, exp, d);
    endtask

    // poll status under a bound; a stuck flag shows as a mismatch
    task automatic wait_idle;
        logic [31:0] s;
        int k;
        s = 32'hFFFF_FFFF;
        k = 0;
        while (s !== 32'h0000_0000 && k < 40)
        begin
            xfer(1'b0, `IWD_OFS_STATUS, 32'h0000_0000, s);
            k++;
        end
        chk("busy flags clear", 32'h0000_0000, s);
    endtask

    // cycles until the reset request is seen, bounded
    task automatic wait_expiry;
        n = 0;
        while (wdog_reset_req !== 1'b1 && n < 300)
        begin
            @(posedge hclk);
            n++;
        end
    endtask

    initial
    begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0000_0000;
        osc_clk_pin = 1'b0;
        osc_div = 3'h0;
        hw_start_pin = 1'b0;
        rdata_smp = 32'h0000_0000;
        n_mismatch = 0;
        cmp_count = 0;
        cyc = 0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        // reset values and the unmapped hole
        rd_chk("divider reset", `IWD_OFS_DIV, 32'h0000_0000);
        rd_chk("reload reset", `IWD_OFS_RELOAD, 32'h0000_0FFF);
        rd_chk("status reset", `IWD_OFS_STATUS, 32'h0000_0000);
        rd_chk("key read", `IWD_OFS_KEY, 32'h0000_0000);
        rd_chk("unmapped", 8'h1C, 32'h0000_0000);
        $display("test reset values done");
        // locked writes vanish; a stray key relocks
        wr(`IWD_OFS_DIV, 32'h0000_0005);
        wr(`IWD_OFS_RELOAD, 32'h0000_0123);
        rd_chk("locked divider", `IWD_OFS_DIV, 32'h0000_0000);
        rd_chk("locked reload", `IWD_OFS_RELOAD, 32'h0000_0FFF);
        key(`IWD_KEY_UNLOCK);
        key(16'h1234);
        wr(`IWD_OFS_RELOAD, 32'h0000_0123);
        rd_chk("relocked reload", `IWD_OFS_RELOAD, 32'h0000_0FFF);
        $display("test protection done");
        // second write lands while busy and must be dropped
        key(`IWD_KEY_UNLOCK);
        wr(`IWD_OFS_RELOAD, 32'h0000_0003);
        wr(`IWD_OFS_RELOAD, 32'h0000_0007);
        xfer(1'b0, `IWD_OFS_STATUS, 32'h0000_0000, st);
        chk("reload busy", 32'h0000_0002, st & 32'h0000_0002);
        wait_idle;
        rd_chk("reload value", `IWD_OFS_RELOAD, 32'h0000_0003);
        for (int i = 7; i >= 0; i--)
        begin
            wr(`IWD_OFS_DIV, i);
            wr(`IWD_OFS_DIV, i ^ 1);
            xfer(1'b0, `IWD_OFS_STATUS, 32'h0000_0000, st);
            chk("divider busy", 32'h0000_0001, st & 32'h0000_0001);
            wait_idle;
            rd_chk("divider code", `IWD_OFS_DIV, i);
        end
        $display("test busy and divider done");
        // refresh event: masked, unmasked, cleared
        wr(`IWD_OFS_IRQ_MASK, 32'h0000_0001);
        key(`IWD_KEY_REFRESH);
        rd_chk("refresh event", `IWD_OFS_IRQ_STS, 32'h0000_0002);
        chk("irq masked", 32'h0000_0000, {31'h0, irq});
        wr(`IWD_OFS_IRQ_MASK, 32'h0000_0003);
        repeat (2) @(posedge hclk);
        #1 chk("irq unmasked", 32'h0000_0001, {31'h0, irq});
        wr(`IWD_OFS_IRQ_STS, 32'h0000_0002);
        rd_chk("event cleared", `IWD_OFS_IRQ_STS, 32'h0000_0000);
        chk("irq cleared", 32'h0000_0000, {31'h0, irq});
        $display("test interrupt done");
        // configure in order, keep alive, then let it expire
        key(`IWD_KEY_UNLOCK);
        wait_idle;
        wr(`IWD_OFS_DIV, 32'h0000_0000);
        wr(`IWD_OFS_RELOAD, 32'h0000_0003);
        key(`IWD_KEY_REFRESH);
        key(`IWD_KEY_START);
        repeat (5)
        begin
            repeat (40) @(posedge hclk);
            key(`IWD_KEY_REFRESH);
            chk("no expiry", 32'h0000_0000, {31'h0, wdog_reset_req});
        end
        // 3 ticks of 4 oscillator edges, 8 bus cycles each
        wait_expiry;
        chk("expiry", 32'h0000_0001, {31'h0, wdog_reset_req});
        chk("expiry time", 32'h0000_0001,
            {31'h0, (n >= 80 && n <= 130)});
        xfer(1'b0, `IWD_OFS_IRQ_STS, 32'h0000_0000, st);
        chk("expiry event", 32'h0000_0001, st & 32'h0000_0001);
        chk("irq on expiry", 32'h0000_0001, {31'h0, irq});
        $display("test expiry done");
        // second reset with the strap high: runs with no start key
        @(posedge hclk);
        hresetn <= 1'b0;
        hw_start_pin <= 1'b1;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (16) @(posedge hclk);
        #1;
        chk("reset drops req", 32'h0000_0000, {31'h0, wdog_reset_req});
        rd_chk("strap latched", `IWD_OFS_CTRL, 32'h0000_0001);
        rd_chk("reload after reset", `IWD_OFS_RELOAD, 32'h0000_0FFF);
        key(`IWD_KEY_UNLOCK);
        wait_idle;
        wr(`IWD_OFS_RELOAD, 32'h0000_0002);
        wait_idle;
        key(`IWD_KEY_REFRESH);
        // 2 ticks after the refresh, no start key issued
        wait_expiry;
        chk("strap expiry", 32'h0000_0001, {31'h0, wdog_reset_req});
        chk("strap expiry time", 32'h0000_0001,
            {31'h0, (n >= 40 && n <= 90)});
        $display("test hardware start done");
        tally_and_finish;
    end
endmodule
`default_nettype wire
